// File: pfc_host.sv
// pfc_host.sv: host-side sequencer driving a 256K x 8 parallel flash over its pins
// assumes flash pins wired to this module; byte data bus resolved outside from byte_data_bus_oe
`include "pfc_map.svh"
module pfc_host (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   // user request
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire logic [2:0]             req_op,
   input  wire logic [`PFC_ADDR_W-1:0] req_addr,
   input  wire logic [`PFC_DATA_W-1:0] req_data,
   // user answer
   output logic                        rsp_valid,
   output logic [`PFC_DATA_W-1:0]      rsp_data,
   // flash pins
   output logic                        chip_en_n,
   output logic                        out_en_n,
   output logic                        wr_en_n,
   output logic                        prog_supply_on,
   output logic [`PFC_ADDR_W-1:0]      array_address_bus,
   output logic [`PFC_DATA_W-1:0]      byte_data_bus_out,
   output logic                        byte_data_bus_oe,
   input  wire logic [`PFC_DATA_W-1:0] byte_data_bus_in
);

   typedef enum logic [3:0] {
      PFC_IDLE, PFC_VPP, PFC_WSET, PFC_WLOW, PFC_WHIGH, PFC_WAIT,
      PFC_RSET, PFC_RLOW, PFC_DONE
   } pfc_st_e;

   localparam int unsigned CNT_W = 22;
   localparam logic [CNT_W-1:0] WP_C    = CNT_W'(`PFC_WP_CYC);
   localparam logic [CNT_W-1:0] WPH_C   = CNT_W'(`PFC_WPH_CYC);
   localparam logic [CNT_W-1:0] WC_C    = CNT_W'(`PFC_WC_CYC);
   localparam logic [CNT_W-1:0] VPEL_C  = CNT_W'(`PFC_VPEL_CYC);
   localparam logic [CNT_W-1:0] WHGL_C  = CNT_W'(`PFC_WHGL_CYC);
   localparam logic [CNT_W-1:0] PROG_C  = CNT_W'(`PFC_PROG_CYC);

   // erase wait exceeds 4096 cycles, so it is shortenable in simulation
   parameter int unsigned ERASE_CYC = `PFC_ERASE_CYC;

   pfc_st_e                 st_q;
   logic [CNT_W-1:0]        cnt_q;
   pfc_pkg::pfc_op_e        op_q;
   logic [1:0]              step_q;
   logic [`PFC_ADDR_W-1:0]  addr_q;
   logic [`PFC_DATA_W-1:0]  data_q;
   logic [`PFC_DATA_W-1:0]  rd_s1_q;
   logic [`PFC_DATA_W-1:0]  rd_s2_q;
   logic                    vpp_q;
   logic                    rsp_q;
   logic [`PFC_DATA_W-1:0]  rsp_data_q;
   logic [CNT_W-1:0]        wait_len;
   logic [1:0]              n_writes;
   logic [`PFC_DATA_W-1:0]  cmd_byte;
   logic                    op_reads;
   logic                    op_known;
   logic [`PFC_ADDR_W-1:0]  addr_out_q;
   logic [`PFC_DATA_W-1:0]  data_out_q;

   assign req_ready = (st_q == PFC_IDLE);
   assign rsp_valid = rsp_q;
   assign rsp_data  = rsp_data_q;
   assign prog_supply_on = vpp_q;

   assign op_known = (req_op <= 3'(pfc_pkg::PFC_OP_RESET));

   // per-operation sequence: writes needed, command byte, recovery, read-back
   always_comb begin
      n_writes = 2'd1;
      cmd_byte = `PFC_CMD_READ;
      wait_len = WC_C;
      op_reads = 1'b1;
      case (op_q)
         pfc_pkg::PFC_OP_READ: begin
            cmd_byte = `PFC_CMD_READ;
         end
         pfc_pkg::PFC_OP_SIG: begin
            cmd_byte = `PFC_CMD_SIG;
         end
         pfc_pkg::PFC_OP_ERASE: begin
            n_writes = 2'd2;
            cmd_byte = `PFC_CMD_ERASE;
            wait_len = CNT_W'(ERASE_CYC);
            op_reads = 1'b0;
         end
         pfc_pkg::PFC_OP_ERASE_VFY: begin
            cmd_byte = `PFC_CMD_ERASE_VFY;
            wait_len = WHGL_C;
         end
         pfc_pkg::PFC_OP_PROG: begin
            n_writes = 2'd2;
            cmd_byte = (step_q == 2'd0) ? `PFC_CMD_PROG : data_q;
            wait_len = PROG_C;
            op_reads = 1'b0;
         end
         pfc_pkg::PFC_OP_PROG_VFY: begin
            cmd_byte = `PFC_CMD_PROG_VFY;
            wait_len = WHGL_C;
         end
         pfc_pkg::PFC_OP_RESET: begin
            n_writes = 2'd2;
            cmd_byte = `PFC_CMD_RESET;
            op_reads = 1'b0;
         end
         default: begin
            op_reads = 1'b0;
         end
      endcase
   end

   // read data comes from a pin, so it is synchronised before capture
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_s1_q <= '0;
         rd_s2_q <= '0;
      end else if (clk_en) begin
         rd_s1_q <= byte_data_bus_in;
         rd_s2_q <= rd_s1_q;
      end
   end

   // sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q   <= PFC_IDLE;
         cnt_q  <= '0;
         op_q   <= pfc_pkg::PFC_OP_READ;
         step_q <= 2'd0;
         addr_q <= '0;
         data_q <= '0;
         vpp_q  <= 1'b0;
         rsp_q  <= 1'b0;
         rsp_data_q <= '0;
      end else if (clk_en) begin
         rsp_q <= 1'b0;
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
         case (st_q)
            PFC_IDLE: begin
               step_q <= 2'd0;
               if (req_valid) begin
                  if (!op_known) begin
                     rsp_q <= 1'b1;
                     rsp_data_q <= '0;
                  end else begin
                     op_q   <= pfc_pkg::pfc_op_e'(req_op);
                     addr_q <= req_addr;
                     data_q <= req_data;
                     vpp_q  <= 1'b1;
                     cnt_q  <= VPEL_C;
                     st_q   <= PFC_VPP;
                  end
               end
            end
            PFC_VPP: begin
               if (cnt_q == '0) begin
                  st_q <= PFC_WSET;
               end
            end
            PFC_WSET: begin
               // address settles before write enable falls; data only needs to stand at the rise
               cnt_q <= WP_C;
               st_q  <= PFC_WLOW;
            end
            PFC_WLOW: begin
               if (cnt_q == '0) begin
                  cnt_q <= (WC_C > WP_C + WPH_C) ? WC_C - WP_C : WPH_C;
                  st_q  <= PFC_WHIGH;
               end
            end
            PFC_WHIGH: begin
               if (cnt_q == '0) begin
                  if (step_q + 2'd1 < n_writes) begin
                     step_q <= step_q + 2'd1;
                     st_q   <= PFC_WSET;
                  end else begin
                     cnt_q <= wait_len;
                     st_q  <= PFC_WAIT;
                  end
               end
            end
            PFC_WAIT: begin
               if (cnt_q == '0) begin
                  if (op_q == pfc_pkg::PFC_OP_ERASE) begin
                     // erase pulse is closed by a verify write at the request address
                     op_q  <= pfc_pkg::PFC_OP_ERASE_VFY;
                     step_q <= 2'd0;
                     st_q  <= PFC_WSET;
                  end else if (op_q == pfc_pkg::PFC_OP_PROG) begin
                     op_q  <= pfc_pkg::PFC_OP_PROG_VFY;
                     step_q <= 2'd0;
                     st_q  <= PFC_WSET;
                  end else if (op_reads) begin
                     st_q <= PFC_RSET;
                  end else begin
                     st_q <= PFC_DONE;
                  end
               end
            end
            PFC_RSET: begin
               cnt_q <= WC_C + CNT_W'(2); // access time plus synchroniser
               st_q  <= PFC_RLOW;
            end
            PFC_RLOW: begin
               if (cnt_q == '0) begin
                  rsp_data_q <= rd_s2_q;
                  st_q <= PFC_DONE;
               end
            end
            PFC_DONE: begin
               rsp_q <= 1'b1;
               vpp_q <= 1'b0;
               st_q  <= PFC_IDLE;
            end
            default: begin
               st_q <= PFC_IDLE;
            end
         endcase
      end
   end

   // bus values come from flops, one cycle behind the sequence; a new command byte
   // may appear as write enable falls, which is safe since the flash takes it at the rise
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addr_out_q <= '0;
         data_out_q <= '0;
      end else if (clk_en) begin
         data_out_q <= cmd_byte;
         // signature reads use 0000H or 0001H with every other line low
         if (op_q == pfc_pkg::PFC_OP_SIG) begin
            addr_out_q <= addr_q[0] ? `PFC_SIG_DEV_ADDR : `PFC_SIG_MFG_ADDR;
         end else begin
            addr_out_q <= addr_q;
         end
      end
   end

   // pin drive from state; chip enable high outside a cycle keeps standby
   always_comb begin
      chip_en_n         = !(st_q == PFC_WSET || st_q == PFC_WLOW || st_q == PFC_WHIGH ||
                            st_q == PFC_RSET || st_q == PFC_RLOW);
      wr_en_n           = (st_q != PFC_WLOW);
      out_en_n          = (st_q != PFC_RLOW);
      byte_data_bus_oe  = (st_q == PFC_WSET || st_q == PFC_WLOW || st_q == PFC_WHIGH);
      byte_data_bus_out = data_out_q;
      array_address_bus = addr_out_q;
   end

endmodule : pfc_host

// File: pfc_map.svh
// pfc_map.svh: pin-level constants for the parallel flash host controller
// assumes a 250 MHz system clock; included by the package and the controller
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
`define PFC_CLK_MHZ        250
`define PFC_ADDR_W         18
`define PFC_DATA_W         8
`define PFC_CMD_READ       8'h00
`define PFC_CMD_SIG        8'h90
`define PFC_CMD_ERASE      8'h20
`define PFC_CMD_ERASE_VFY  8'hA0
`define PFC_CMD_PROG       8'h40
`define PFC_CMD_PROG_VFY   8'hC0
`define PFC_CMD_RESET      8'hFF
`define PFC_SIG_MFG_ADDR   18'h00000
`define PFC_SIG_DEV_ADDR   18'h00001
// strobe and wait timing in ns (erase in us), cycle counts derived (least times round up)
`define PFC_T_WP_NS        40
`define PFC_T_WPH_NS       20
`define PFC_T_WC_NS        120
`define PFC_T_VPEL_NS      100
`define PFC_T_WHGL_NS      6000
`define PFC_T_PROG_NS      10000
`define PFC_T_ERASE_US     9500
`define PFC_CYC(ns)        (((ns) * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_WP_CYC         `PFC_CYC(`PFC_T_WP_NS)
`define PFC_WPH_CYC        `PFC_CYC(`PFC_T_WPH_NS)
`define PFC_WC_CYC         `PFC_CYC(`PFC_T_WC_NS)
`define PFC_VPEL_CYC       `PFC_CYC(`PFC_T_VPEL_NS)
`define PFC_WHGL_CYC       `PFC_CYC(`PFC_T_WHGL_NS)
`define PFC_PROG_CYC       `PFC_CYC(`PFC_T_PROG_NS)
`define PFC_ERASE_CYC      (`PFC_T_ERASE_US * `PFC_CLK_MHZ)
`endif

// File: pfc_pkg.sv
// pfc_pkg.sv: types shared by the parallel flash host controller
// assumes pfc_map.svh is on the include path
`include "pfc_map.svh"
package pfc_pkg;
   // user operations
   typedef enum logic [2:0] {
      PFC_OP_READ,
      PFC_OP_SIG,
      PFC_OP_ERASE,
      PFC_OP_ERASE_VFY,
      PFC_OP_PROG,
      PFC_OP_PROG_VFY,
      PFC_OP_RESET
   } pfc_op_e;
endpackage : pfc_pkg

// File: pfc_host_monitor.sv
// pfc_host_monitor.sv: pin-level protocol checks on the flash host controller
// assumes it is bound to every pfc_host and sees only that module's ports
module pfc_host_monitor (
   // clock, reset, user side
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [2:0]  req_op,
   input wire logic        rsp_valid,
   // flash pins
   input wire logic        chip_en_n,
   input wire logic        out_en_n,
   input wire logic        wr_en_n,
   input wire logic        prog_supply_on,
   input wire logic [17:0] array_address_bus,
   input wire logic [7:0]  byte_data_bus_out,
   input wire logic        byte_data_bus_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_IDLE: assert property (req_ready |-> chip_en_n && wr_en_n && !byte_data_bus_oe)
      else $error("strobes active while idle");
   AST_STANDBY: assert property (chip_en_n |-> out_en_n && wr_en_n)
      else $error("strobe without chip enable");
   AST_READ_BUS: assert property (!out_en_n |-> !byte_data_bus_oe && wr_en_n)
      else $error("bus driven during read");
   AST_WRITE_QUAL: assert property (!wr_en_n |-> !chip_en_n && prog_supply_on && byte_data_bus_oe)
      else $error("write without supply or data");
   // supply must lead chip enable by 100 ns, i.e. 25 cycles
   AST_SUPPLY_LEAD: assert property ($fell(chip_en_n) |-> $past(prog_supply_on, 25))
      else $error("supply setup too short");
   // write enable low for at least 40 ns, i.e. 10 cycles from the falling sample
   AST_WE_LOW: assert property ($fell(wr_en_n) |-> !wr_en_n [*8] ##1 !wr_en_n [*2])
      else $error("write pulse too short");
   AST_WE_HIGH: assert property ($rose(wr_en_n) |-> wr_en_n [*5])
      else $error("write high time too short");
   AST_WR_HOLD: assert property (!wr_en_n |=> $stable(byte_data_bus_out) && $stable(array_address_bus))
      else $error("address or data moved in write");
   AST_REFUSE: assert property (clk_en && req_valid && req_ready && req_op == 3'h7 |=> ##[0:1] rsp_valid)
      else $error("refused op not answered");
   // a frozen clock enable holds the answer, so only an enabled cycle must clear it
   AST_RSP_PULSE: assert property (rsp_valid && clk_en |=> !rsp_valid)
      else $error("answer longer than one cycle");
endmodule : pfc_host_monitor

bind pfc_host pfc_host_monitor i_pfc_host_monitor (.clk_sys, .rst, .clk_en, .req_valid, .req_ready, .req_op,
   .rsp_valid, .chip_en_n, .out_en_n, .wr_en_n, .prog_supply_on, .array_address_bus, .byte_data_bus_out,
   .byte_data_bus_oe);

// File: pfc_flash_model.sv
// pfc_flash_model.sv: behavioural 256K x 8 flash seen from its pins
// assumes a host on the strobes; counts protocol faults of the host in viol
module pfc_flash_model #(
   parameter logic [7:0] MFG_CODE = 8'h5A, // arbitrary
   parameter logic [7:0] DEV_CODE = 8'hA5  // arbitrary
) (
   // strobes and buses from the host
   input wire logic        chip_en_n,
   input wire logic        out_en_n,
   input wire logic        wr_en_n,
   input wire logic        prog_supply_on,
   input wire logic [17:0] array_address_bus,
   input wire logic [7:0]  byte_data_bus_out,
   input wire logic        byte_data_bus_oe,
   // answer and fault count
   output logic [7:0]      byte_data_bus_in,
   output int              viol
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0]  mem [int];
   logic [17:0] la = 18'h00000;
   logic [17:0] la_nx = 18'h00000;
   logic [7:0]  prev = 8'h00;
   logic [7:0]  last = 8'h00;
   logic [1:0]  rmode = 2'h0;
   logic        prog_arm = 1'b0;
   logic        erasing = 1'b0;
   realtime     t_w = -1.0e6;
   function automatic logic [7:0] rd(input logic [17:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
   endfunction : rd
   initial viol = 0;
   always @(negedge wr_en_n) la_nx = array_address_bus;
   always @(posedge wr_en_n) begin
      if (!chip_en_n && prog_supply_on) begin
         if (!byte_data_bus_oe) viol++;
         if (prog_arm) begin
            la = la_nx;
            mem[int'(la)] = rd(la) & byte_data_bus_out;
            prog_arm = 1'b0;
            t_w = $realtime;
         end else begin
            case (byte_data_bus_out)
               8'h00: rmode = 2'h0;
               8'h90: rmode = 2'h1;
               8'h40: prog_arm = 1'b1;
               8'hC0: rmode = 2'h3;
               8'h20: erasing = erasing || prev == 8'h20;
               8'hA0: begin
                  if (erasing) mem.delete();
                  if (erasing) t_w = $realtime;
                  erasing = 1'b0;
                  la = la_nx;
                  rmode = 2'h2;
               end
               8'hFF: if (prev == 8'hFF) rmode = 2'h0;
               default: rmode = 2'h0;
            endcase
         end
         prev = byte_data_bus_out;
      end
   end
   // released bus shows the inverse of the last byte so a stale sample cannot pass
   always @(chip_en_n or out_en_n or wr_en_n or array_address_bus) begin
      if (!chip_en_n && !out_en_n && wr_en_n) begin
         if ($realtime - t_w < 6000.0) viol++;
         case (rmode)
            2'h0: last = rd(array_address_bus);
            2'h1: last = array_address_bus[0] ? DEV_CODE : MFG_CODE;
            default: last = rd(la);
         endcase
         byte_data_bus_in = last;
      end else begin
         byte_data_bus_in = ~last;
      end
   end
endmodule : pfc_flash_model

// File: pfc_tb.sv
// pfc_tb.sv: self-checking bench for the flash host controller against a flash model
// assumes pfc_pkg, pfc_host, pfc_flash_model and pfc_host_monitor compiled first
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MFG = 8'h5A; // arbitrary
   localparam logic [7:0] DEV = 8'hA5; // arbitrary
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   logic [31:0] ce_rnd = 32'h54C1E116;
   logic [7:0]  last_rd = 8'h00;
   logic        req_valid = 1'b0;
   logic [2:0]  req_op = 3'h0;
   logic [17:0] req_addr = 18'h00000;
   logic [7:0]  req_data = 8'h00;
   logic        req_ready, rsp_valid, chip_en_n, out_en_n, wr_en_n, prog_supply_on, byte_data_bus_oe;
   logic [7:0]  rsp_data, byte_data_bus_out, byte_data_bus_in;
   logic [17:0] array_address_bus;
   logic [17:0] last_pa = 18'h00000;
   logic [31:0] seed = 32'h54C1E116;
   logic [7:0]  bm [int];
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          viol;
   // erase shortened so the run stays short
   pfc_host #(.ERASE_CYC(200)) i_pfc_host (.clk_sys, .rst, .clk_en, .req_valid, .req_ready, .req_op,
      .req_addr, .req_data, .rsp_valid, .rsp_data, .chip_en_n, .out_en_n, .wr_en_n, .prog_supply_on,
      .array_address_bus, .byte_data_bus_out, .byte_data_bus_oe, .byte_data_bus_in);
   pfc_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) i_pfc_flash_model (.chip_en_n, .out_en_n, .wr_en_n,
      .prog_supply_on, .array_address_bus, .byte_data_bus_out, .byte_data_bus_oe, .byte_data_bus_in, .viol);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] bget(input logic [17:0] a);
      return bm.exists(int'(a)) ? bm[int'(a)] : 8'hFF;
   endfunction : bget
   task automatic give_verdict;
      if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic do_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
      logic [7:0] exp;
      int         n;
      if (op == 3'h2) bm.delete();
      if (op == 3'h4) bm[int'(a)] = bget(a) & d;
      if (op == 3'h4) last_pa = a;
      exp = (op == 3'h5) ? bget(last_pa) : bget(a);
      if (op == 3'h1) exp = a[0] ? DEV : MFG;
      if (op == 3'h6) exp = last_rd;
      if (op == 3'h7) exp = 8'h00;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      do @(negedge clk_sys); while (req_ready !== 1'b1);
      @(posedge clk_sys);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      if (rsp_valid !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH %0t no answer to op %0d", $time, op);
      end
      check(rsp_data, exp);
      last_rd = exp;
   endtask : do_op
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      // freeze now and then, only in a cycle after a busy one, so a request is never lost at its accept edge
      ce_rnd <= lfsr(ce_rnd);
      clk_en <= (req_ready === 1'b1) || (ce_rnd[3:2] != 2'b00);
      if (cyc == 60000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      do_op(3'h0, 18'h3FFFF, 8'h00);
      for (int i = 0; i < 2; i++) do_op(3'h1, 18'(i), 8'h00);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         do_op(3'h4, seed[17:0], seed[31:24]);
         do_op(3'h0, seed[17:0], 8'h00);
      end
      do_op(3'h4, seed[17:0], seed[15:8]);
      do_op(3'h5, 18'h00000, 8'h00);
      do_op(3'h2, 18'h00000, 8'h00);
      do_op(3'h3, seed[17:0], 8'h00);
      do_op(3'h6, 18'h00000, 8'h00);
      do_op(3'h7, 18'h00000, 8'h00);
      do_op(3'h0, seed[17:0], 8'h00);
      check((viol == 0) ? 8'h00 : 8'hFF, 8'h00);
      give_verdict();
   end
endmodule : testbench
